// [verilog/phase_overcurrent_stages.sv]
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/100ps

// Summary of operation
// - low-set start asserts about 55 ms after any phase exceeds its value
// - started low-set trips when definite or inverse operate time expires
// - started untripped low-set holds start for resetting time after drop
// - current back above value during resetting keeps low-set start high
// - tripped low-set resets 50 ms after all phases below half value
// - option: low-set inverse timing halts while high-set or inst started
// - assigned digital input blocks low-set tripping
// - high-set starts after about 30 ms, trips after definite time
// - high-set and instantaneous operate time never below 40 ms
// - inrush rise below 0.12 to above 1.5 low-set in 60 ms doubles
// - doubling ends after all phases below 1.25 low-set for 200 ms
// - assigned digital input blocks high-set tripping
// - high-set, instantaneous can be disabled; start value reads 999
// - instantaneous starts after about 30 ms, trips after definite time
// - high-set and instantaneous reset 50 ms after phases below value
// - auto-reclose block signal blocks low-set and high-set when enabled
module phase_overcurrent_stages
	import oc_stages_pkg::*;
#(
	parameter int CYCLES_PER_MS = TICK_CYCLES
) (
	input  logic        clk_i,
	input  logic        rst_i,
	input  wb_req_t     wb_i,
	output logic        wb_ack_o,
	output logic [31:0] wb_dat_o,
	input  logic        sample_tick_i,
	input  phase_t      cur_i,
	input  logic [1:0]  blk_pins_i,
	input  logic        ar_block_i,
	output stage_out_t  stage_o
);

	if (CYCLES_PER_MS < 2 || CYCLES_PER_MS > (1 << DIV_W)) begin : g_bad
		$error("CYCLES_PER_MS out of range");
	end
	core_t       q;
	core_t       n;
	logic [15:0] imax;
	logic [16:0] eff [3];
	logic [2:0]  over;
	logic [2:0]  off;
	logic [2:0]  block;
	logic [2:0]  op_done;
	logic [2:0]  starts;
	logic [2:0]  trips;
	logic        half_low;
	logic        lo_now;
	logic        hi_now;
	logic        end_low;
	logic        inhibit;
	logic        req;
	logic [7:0]  adr;
	function automatic logic [23:0] scale(input logic [15:0] v,
		input logic [7:0] k);
		scale = 24'(v) * 24'(k);
	endfunction
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		merge16 = {sel[1] ? dat[15:8] : old[15:8],
			sel[0] ? dat[7:0] : old[7:0]};
	endfunction
	// operate time floor keeps high stages from tripping below 40 ms
	function automatic logic [15:0] clamp_op(input logic [15:0] v);
		clamp_op = (v < MIN_OPER_MS) ? MIN_OPER_MS : v;
	endfunction
	function automatic logic [31:0] read_word(input core_t c,
		input logic [7:0] a, input logic [2:0] st, input logic [2:0] tp);
		if (a == REG_CTRL) begin
			read_word = {24'h000000, c.ctrl};
		end else if (a == REG_STATUS) begin
			read_word = {23'h0, c.dbl, tp, st, c.blk};
		end else if (a == REG_LS_THR) begin
			read_word = {16'h0000, c.thr[LS]};
		end else if (a == REG_HS_THR) begin
			read_word = {16'h0000,
				c.ctrl[CTL_HS_OFF] ? OFF_READBACK : c.thr[HS]};
		end else if (a == REG_IN_THR) begin
			read_word = {16'h0000,
				c.ctrl[CTL_IN_OFF] ? OFF_READBACK : c.thr[IN]};
		end else if (a == REG_LS_OPT) begin
			read_word = {16'h0000, c.opt[LS]};
		end else if (a == REG_HS_OPT) begin
			read_word = {16'h0000, c.opt[HS]};
		end else if (a == REG_IN_OPT) begin
			read_word = {16'h0000, c.opt[IN]};
		end else if (a == REG_LS_RST) begin
			read_word = {16'h0000, c.ls_rst};
		end else if (a == REG_LS_K) begin
			read_word = {16'h0000, c.ls_k};
		end else begin
			read_word = 32'h00000000;
		end
	endfunction
	assign imax = (q.cur.i1 >= q.cur.i2 && q.cur.i1 >= q.cur.i3) ? q.cur.i1
		: (q.cur.i2 >= q.cur.i3) ? q.cur.i2 : q.cur.i3;
	assign half_low = scale(imax, HALF_DEN) < scale(q.thr[LS], HALF_NUM);
	assign lo_now   = scale(imax, INR_LO_DEN) < scale(q.thr[LS], INR_LO_NUM);
	assign hi_now   = scale(imax, INR_HI_DEN) > scale(q.thr[LS], INR_HI_NUM);
	assign end_low  = scale(imax, INR_END_DEN) < scale(q.thr[LS], INR_END_NUM);
	assign off      = {q.ctrl[CTL_IN_OFF], q.ctrl[CTL_HS_OFF], 1'b0};
	assign block[LS] = (q.ctrl[CTL_DI_LS] & q.blk[0])
		| (q.ctrl[CTL_AR_BLK] & ar_block_i);
	assign block[HS] = (q.ctrl[CTL_DI_HS] & q.blk[1])
		| (q.ctrl[CTL_AR_BLK] & ar_block_i);
	assign block[IN] = 1'b0;
	// inverse timing pauses while a faster stage owns the fault
	assign inhibit = q.ctrl[CTL_INHIBIT] & q.ctrl[CTL_LS_INV]
		& (q.ss[HS] != IDLE | q.ss[IN] != IDLE);
	assign op_done[LS] = q.ctrl[CTL_LS_INV]
		? (q.acc >= 32'(q.ls_k) * 32'(q.thr[LS])) : (q.opc[LS] >= q.opt[LS]);
	assign op_done[HS] = q.opc[HS] >= q.opt[HS];
	assign op_done[IN] = q.opc[IN] >= q.opt[IN];
	assign req = wb_i.cyc & wb_i.stb & ~q.ack;
	assign adr = {wb_i.adr[7:2], 2'b00};
	for (genvar g = 0; g < 3; g++) begin : g_stage
		assign eff[g] = (g == HS && q.dbl) ? {q.thr[g], 1'b0}
			: {1'b0, q.thr[g]};
		assign over[g] = ({1'b0, q.cur.i1} > eff[g])
			| ({1'b0, q.cur.i2} > eff[g]) | ({1'b0, q.cur.i3} > eff[g]);
		assign starts[g] = q.ss[g] != IDLE;
		assign trips[g]  = q.ss[g] == TRIPPED;
	end
	always_comb begin
		n = q;
		n.tick = 1'b0;
		if (q.div == DIV_W'(CYCLES_PER_MS - 1)) begin
			n.div  = '0;
			n.tick = 1'b1;
		end else begin
			n.div = q.div + 1'b1;
		end
		// pins: blk only updates when second and third stages agree
		n.s1  = blk_pins_i;
		n.s2  = q.s1;
		n.s3  = q.s2;
		n.blk = (q.s2 & q.s3) | (q.blk & (q.s2 ^ q.s3));
		if (sample_tick_i) begin
			n.cur = cur_i;
		end
		for (int s = 0; s < 3; s++) begin
			if (off[s]) begin
				n.ss[s]   = IDLE;
				n.dly[s]  = '0;
				n.opc[s]  = '0;
				n.rstc[s] = '0;
			end else if (q.tick) begin
				case (q.ss[s])
					IDLE: begin
						n.rstc[s] = '0;
						if (over[s]) begin
							n.dly[s] = q.dly[s] + 1'b1;
							if (n.dly[s] >= ((s == LS) ? LS_START_DLY_MS
								: HI_START_DLY_MS)) begin
								n.ss[s]  = STARTED;
								n.dly[s] = '0;
								n.opc[s] = '0;
							end
						end else begin
							n.dly[s] = '0;
						end
					end
					STARTED: begin
						if (over[s]) begin
							n.rstc[s] = '0;
							if (s == LS && q.ctrl[CTL_LS_INV]) begin
								if (!inhibit && !op_done[LS]) begin
									n.acc = q.acc + 32'(imax - q.thr[LS]);
								end
							end else if (!op_done[s]) begin
								n.opc[s] = q.opc[s] + 1'b1;
							end
							if (op_done[s] && !block[s]) begin
								n.ss[s] = TRIPPED;
							end
						end else begin
							// operate timer freezes while the reset timer runs
							n.rstc[s] = q.rstc[s] + 1'b1;
							if (n.rstc[s] >= ((s == LS) ? q.ls_rst
								: TRIP_RESET_MS)) begin
								n.ss[s]   = IDLE;
								n.rstc[s] = '0;
								n.opc[s]  = '0;
							end
						end
					end
					default: begin
						if ((s == LS) ? half_low : !over[s]) begin
							n.rstc[s] = q.rstc[s] + 1'b1;
							if (n.rstc[s] >= TRIP_RESET_MS) begin
								n.ss[s]   = IDLE;
								n.rstc[s] = '0;
								n.opc[s]  = '0;
							end
						end else begin
							n.rstc[s] = '0;
						end
					end
				endcase
			end
		end
		if (q.ss[LS] == IDLE) begin
			n.acc = '0;
		end
		if (q.tick) begin
			if (lo_now) begin
				n.armed = 1'b1;
				n.rise  = '0;
			end else if (q.rise < INRUSH_RISE_MS) begin
				n.rise = q.rise + 1'b1;
			end else begin
				n.armed = 1'b0;
			end
			if (q.armed && q.rise < INRUSH_RISE_MS && hi_now) begin
				n.dbl = 1'b1;
			end
			if (q.dbl) begin
				if (end_low) begin
					n.fall = q.fall + 1'b1;
					if (n.fall >= INRUSH_END_MS) begin
						n.dbl  = 1'b0;
						n.fall = '0;
					end
				end else begin
					n.fall = '0;
				end
			end
		end
		if (!q.ctrl[CTL_DOUBLE]) begin
			n.dbl  = 1'b0;
			n.fall = '0;
		end
		n.ack = req;
		if (req) begin
			n.rdat = read_word(q, adr, starts, trips);
			if (wb_i.we) begin
				if (adr == REG_CTRL) begin
					n.ctrl = wb_i.sel[0] ? wb_i.dat[7:0] : q.ctrl;
				end else if (adr == REG_LS_THR) begin
					n.thr[LS] = merge16(q.thr[LS], wb_i.dat, wb_i.sel);
				end else if (adr == REG_HS_THR) begin
					n.thr[HS] = merge16(q.thr[HS], wb_i.dat, wb_i.sel);
				end else if (adr == REG_IN_THR) begin
					n.thr[IN] = merge16(q.thr[IN], wb_i.dat, wb_i.sel);
				end else if (adr == REG_LS_OPT) begin
					n.opt[LS] = merge16(q.opt[LS], wb_i.dat, wb_i.sel);
				end else if (adr == REG_HS_OPT) begin
					n.opt[HS] = clamp_op(merge16(q.opt[HS], wb_i.dat,
						wb_i.sel));
				end else if (adr == REG_IN_OPT) begin
					n.opt[IN] = clamp_op(merge16(q.opt[IN], wb_i.dat,
						wb_i.sel));
				end else if (adr == REG_LS_RST) begin
					n.ls_rst = merge16(q.ls_rst, wb_i.dat, wb_i.sel);
				end else if (adr == REG_LS_K) begin
					n.ls_k = merge16(q.ls_k, wb_i.dat, wb_i.sel);
				end
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q        <= '0;
			q.thr    <= {IN_THR_RST, HS_THR_RST, LS_THR_RST};
			q.opt    <= {IN_OPT_RST, HS_OPT_RST, LS_OPT_RST};
			q.ls_rst <= LS_RST_RST;
			q.ls_k   <= LS_K_RST;
		end else begin
			q <= n;
		end
	end
	assign wb_ack_o         = q.ack;
	assign wb_dat_o         = q.rdat;
	assign stage_o.ls_start = starts[LS];
	assign stage_o.ls_trip  = trips[LS];
	assign stage_o.hs_start = starts[HS];
	assign stage_o.hs_trip  = trips[HS];
	assign stage_o.in_start = starts[IN];
	assign stage_o.in_trip  = trips[IN];
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	property p_ls_start;
		$rose(starts[LS]) |-> $past(q.dly[LS]) == LS_START_DLY_MS - 16'h0001
			&& $past(over[LS]);
	endproperty
	a_ls_start: assert property (p_ls_start)
		else $error("low-set start not after 55 ms");
	property p_ls_trip;
		$rose(trips[LS]) |-> $past(starts[LS]) && $past(op_done[LS]);
	endproperty
	a_ls_trip: assert property (p_ls_trip)
		else $error("low-set trip without operate time");
	property p_ls_hold;
		$fell(starts[LS]) && !$past(trips[LS])
			|-> $past(q.rstc[LS]) + 16'h0001 >= $past(q.ls_rst);
	endproperty
	a_ls_hold: assert property (p_ls_hold)
		else $error("low-set start released early");
	property p_ls_keep;
		q.ss[LS] == STARTED && over[LS] && q.tick |=> starts[LS];
	endproperty
	a_ls_keep: assert property (p_ls_keep)
		else $error("low-set start dropped while over value");
	property p_ls_trip_rst;
		$fell(trips[LS]) |-> $past(q.rstc[LS]) == TRIP_RESET_MS - 16'h0001
			&& $past(half_low);
	endproperty
	a_ls_trip_rst: assert property (p_ls_trip_rst)
		else $error("tripped low-set reset not at 50 ms");
	property p_ls_block;
		block[LS] && !trips[LS] |=> !trips[LS];
	endproperty
	a_ls_block: assert property (p_ls_block)
		else $error("low-set tripped while blocked");
	property p_hs_start;
		$rose(starts[HS]) |-> $past(q.dly[HS]) == HI_START_DLY_MS - 16'h0001;
	endproperty
	a_hs_start: assert property (p_hs_start)
		else $error("high-set start not after 30 ms");
	property p_min_op;
		q.opt[HS] >= MIN_OPER_MS && q.opt[IN] >= MIN_OPER_MS;
	endproperty
	a_min_op: assert property (p_min_op)
		else $error("operate time below minimum");
	property p_dbl_end;
		$fell(q.dbl) && q.ctrl[CTL_DOUBLE]
			|-> $past(q.fall) == INRUSH_END_MS - 8'h01;
	endproperty
	a_dbl_end: assert property (p_dbl_end)
		else $error("doubling ended before 200 ms");
	property p_hs_block;
		block[HS] && !trips[HS] |=> !trips[HS];
	endproperty
	a_hs_block: assert property (p_hs_block)
		else $error("high-set tripped while blocked");
	property p_readback;
		req && !wb_i.we && adr == REG_HS_THR && q.ctrl[CTL_HS_OFF]
			|=> q.ack && q.rdat == {16'h0000, OFF_READBACK};
	endproperty
	a_readback: assert property (p_readback)
		else $error("disabled high-set start value not 999");
	property p_in_rst;
		$fell(starts[IN]) && !q.ctrl[CTL_IN_OFF]
			|-> $past(q.rstc[IN]) == TRIP_RESET_MS - 16'h0001;
	endproperty
	a_in_rst: assert property (p_in_rst)
		else $error("instantaneous reset not at 50 ms");
	property p_off;
		off[IN] |=> !starts[IN] && q.dly[IN] == 16'h0000;
	endproperty
	a_off: assert property (p_off)
		else $error("disabled stage still active");
	c_ls_trip: cover property ($rose(trips[LS]));
	c_hs_trip: cover property ($rose(trips[HS]));
	c_in_trip: cover property ($rose(trips[IN]));
	c_double:  cover property ($rose(q.dbl));

endmodule

// [verilog/oc_stages_pkg.sv]
package oc_stages_pkg;

	// timebase
	localparam int CLK_HZ      = 125_000_000;
	localparam int MS_PER_S    = 1000;
	localparam int TICK_CYCLES = CLK_HZ / MS_PER_S;
	localparam int DIV_W       = 17;

	// stage indices
	localparam int LS = 0;
	localparam int HS = 1;
	localparam int IN = 2;

	// delays in ms ticks, and the start value read back for a disabled stage
	localparam logic [15:0] LS_START_DLY_MS = 16'h0037;
	localparam logic [15:0] HI_START_DLY_MS = 16'h001E;
	localparam logic [15:0] TRIP_RESET_MS   = 16'h0032;
	localparam logic [15:0] MIN_OPER_MS     = 16'h0028;
	localparam logic [7:0]  INRUSH_RISE_MS  = 8'h3C;
	localparam logic [7:0]  INRUSH_END_MS   = 8'hC8;
	localparam logic [15:0] OFF_READBACK    = 16'h03E7;

	// threshold ratios as numerator / denominator
	localparam logic [7:0] INR_LO_NUM  = 8'h0C;
	localparam logic [7:0] INR_LO_DEN  = 8'h64;
	localparam logic [7:0] INR_HI_NUM  = 8'h03;
	localparam logic [7:0] INR_HI_DEN  = 8'h02;
	localparam logic [7:0] INR_END_NUM = 8'h05;
	localparam logic [7:0] INR_END_DEN = 8'h04;
	localparam logic [7:0] HALF_NUM    = 8'h01;
	localparam logic [7:0] HALF_DEN    = 8'h02;

	// register byte offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_LS_THR = 8'h08;
	localparam logic [7:0] REG_HS_THR = 8'h0C;
	localparam logic [7:0] REG_IN_THR = 8'h10;
	localparam logic [7:0] REG_LS_OPT = 8'h14;
	localparam logic [7:0] REG_HS_OPT = 8'h18;
	localparam logic [7:0] REG_IN_OPT = 8'h1C;
	localparam logic [7:0] REG_LS_RST = 8'h20;
	localparam logic [7:0] REG_LS_K   = 8'h24;

	// control bits: [1:0] disable switches, [7:2] option switches
	localparam int CTL_HS_OFF  = 0;
	localparam int CTL_IN_OFF  = 1;
	localparam int CTL_LS_INV  = 2;
	localparam int CTL_INHIBIT = 3;
	localparam int CTL_DOUBLE  = 4;
	localparam int CTL_AR_BLK  = 5;
	localparam int CTL_DI_LS   = 6;
	localparam int CTL_DI_HS   = 7;

	// values after reset
	localparam logic [15:0] LS_THR_RST = 16'h0100;
	localparam logic [15:0] HS_THR_RST = 16'h0400;
	localparam logic [15:0] IN_THR_RST = 16'h0800;
	localparam logic [15:0] LS_OPT_RST = 16'h03E8;
	localparam logic [15:0] HS_OPT_RST = 16'h0064;
	localparam logic [15:0] IN_OPT_RST = 16'h0028;
	localparam logic [15:0] LS_RST_RST = 16'h0032;
	localparam logic [15:0] LS_K_RST   = 16'h0200;

	typedef enum logic [1:0] {IDLE, STARTED, TRIPPED} stage_state_t;

	typedef struct packed {
		logic [15:0] i3;
		logic [15:0] i2;
		logic [15:0] i1;
	} phase_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_t;

	typedef struct packed {
		logic ls_start;
		logic ls_trip;
		logic hs_start;
		logic hs_trip;
		logic in_start;
		logic in_trip;
	} stage_out_t;

	typedef struct packed {
		logic [DIV_W-1:0]   div;
		logic               tick;
		logic [1:0]         s1;
		logic [1:0]         s2;
		logic [1:0]         s3;
		logic [1:0]         blk;
		phase_t             cur;
		stage_state_t [2:0] ss;
		logic [2:0][15:0]   dly;
		logic [2:0][15:0]   opc;
		logic [2:0][15:0]   rstc;
		logic [31:0]        acc;
		logic               dbl;
		logic               armed;
		logic [7:0]         rise;
		logic [7:0]         fall;
		logic [7:0]         ctrl;
		logic [2:0][15:0]   thr;
		logic [2:0][15:0]   opt;
		logic [15:0]        ls_rst;
		logic [15:0]        ls_k;
		logic               ack;
		logic [31:0]        rdat;
	} core_t;

endpackage

// [verification/current_source.sv]
`timescale 1ns/100ps
module current_source
	import oc_stages_pkg::*;
(
	input  logic   clk_i,
	input  logic   rst_i,
	input  phase_t level_i,
	output logic   tick_o,
	output phase_t cur_o
);
	logic ph_q;
	// one new magnitude frame every second cycle
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ph_q <= 1'b0;
		else
			ph_q <= ~ph_q;
	end
	assign tick_o = ph_q;
	// word is only meaningful with the tick, so show junk in between
	assign cur_o = ph_q ? level_i : ~level_i;
endmodule

// [verification/phase_overcurrent_stages_tb.sv]
`timescale 1ns/100ps
module phase_overcurrent_stages_tb
	import oc_stages_pkg::*;
;
	localparam int CPM = 4;
	localparam logic [7:0] OFFS [10] = '{REG_CTRL, REG_STATUS, REG_LS_THR,
		REG_HS_THR, REG_IN_THR, REG_LS_OPT, REG_HS_OPT, REG_IN_OPT,
		REG_LS_RST, REG_LS_K};
	localparam logic [15:0] DEFS [10] = '{16'h0000, 16'h0000, LS_THR_RST,
		HS_THR_RST, IN_THR_RST, LS_OPT_RST, HS_OPT_RST, IN_OPT_RST,
		LS_RST_RST, LS_K_RST};
	// reclose, high-set pin, low-set pin: unblocked trips form mask m
	localparam logic [31:0] BLK_CTRL [3] = '{32'h20, 32'h80, 32'h40};
	localparam logic [1:0]  BLK_PINS [3] = '{2'b00, 2'b10, 2'b01};
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	wb_req_t     wb = '0;
	logic        wb_ack_o;
	logic [31:0] wb_dat_o;
	logic        tick;
	phase_t      lvl = '0;
	phase_t      cur;
	logic [1:0]  pins = 2'b00;
	logic        ar = 1'b0;
	stage_out_t  so;
	logic [31:0] rd;
	logic [15:0] hi;
	int          failures = 0;
	int          tests_run = 0;

	always #4 clk_i = ~clk_i;

	phase_overcurrent_stages #(.CYCLES_PER_MS(CPM)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_ack_o(wb_ack_o),
		.wb_dat_o(wb_dat_o), .sample_tick_i(tick), .cur_i(cur),
		.blk_pins_i(pins), .ar_block_i(ar), .stage_o(so));

	current_source src (.clk_i(clk_i), .rst_i(rst_i), .level_i(lvl),
		.tick_o(tick), .cur_o(cur));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		if (failures == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic wait_ms(input int n);
		repeat (n * CPM) @(posedge clk_i);
	endtask

	// waits for ack, no fixed latency assumed
	task automatic bus(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 64);
		rd = wb_dat_o;
		wb <= '0;
		if (n >= 64)
			failures++;
	endtask

	// worst phase picked at random, the other two well below it
	task automatic drive(input logic [15:0] v);
		int k;
		phase_t p;
		k = $urandom % 3;
		p = {v >> 2, v >> 2, v >> 2};
		p[k*16 +: 16] = v;
		lvl <= p;
	endtask

	function automatic logic [31:0] thr_rb(input logic off,
		input logic [15:0] v);
		return off ? {16'h0000, OFF_READBACK} : {16'h0000, v};
	endfunction

	function automatic logic [31:0] opt_rb(input logic [15:0] v);
		return {16'h0000, (v < MIN_OPER_MS) ? MIN_OPER_MS : v};
	endfunction

	initial begin
		void'($urandom(56688));
		hi = 16'h0101 + 16'($urandom % 512);
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 10; i++) begin
			bus(OFFS[i], 1'b0, 32'h0);
			check(rd, {16'h0000, DEFS[i]});
		end
		bus(8'h28, 1'b1, 32'hFFFF);
		bus(8'h28, 1'b0, 32'h0);
		check(rd, 32'h0);
		drive(hi);
		wait_ms(52);
		check(32'(so.ls_start), 32'h0);
		wait_ms(6);
		check(32'(so.ls_start), 32'h1);
		drive(16'h00F0);
		wait_ms(30);
		check(32'(so.ls_start), 32'h1);
		drive(hi);
		wait_ms(10);
		drive(16'h00F0);
		wait_ms(40);
		check(32'(so.ls_start), 32'h1);
		wait_ms(15);
		check(32'(so.ls_start), 32'h0);
		bus(REG_LS_OPT, 1'b1, 32'd20);
		drive(hi);
		wait_ms(70);
		check(32'(so.ls_trip), 32'h0);
		wait_ms(12);
		check(32'(so.ls_trip), 32'h1);
		drive(16'($urandom % 128));
		wait_ms(45);
		check(32'(so.ls_trip), 32'h1);
		wait_ms(10);
		check(32'({so.ls_start, so.ls_trip}), 32'h0);
		bus(REG_HS_OPT, 1'b1, 32'd10);
		bus(REG_HS_OPT, 1'b0, 32'h0);
		check(rd, opt_rb(16'd10));
		drive(16'h0900);
		wait_ms(25);
		check(32'({so.hs_start, so.in_start}), 32'h0);
		wait_ms(10);
		check(32'({so.hs_start, so.in_start}), 32'h3);
		wait_ms(30);
		check(32'({so.hs_trip, so.in_trip}), 32'h0);
		wait_ms(15);
		check(32'({so.hs_trip, so.in_trip}), 32'h3);
		drive(16'h0000);
		wait_ms(45);
		check(32'({so.hs_trip, so.in_trip}), 32'h3);
		wait_ms(10);
		check(32'({so.hs_trip, so.in_trip}), 32'h0);
		// blocks held until the stage is idle again
		for (int m = 0; m < 3; m++) begin
			bus(REG_CTRL, 1'b1, BLK_CTRL[m]);
			pins <= BLK_PINS[m];
			ar <= (m == 0);
			drive(16'h0500);
			wait_ms(120);
			check(32'({so.hs_trip, so.ls_trip}), 32'(m));
			drive(16'h0000);
			wait_ms(70);
			pins <= 2'b00;
			ar <= 1'b0;
		end
		bus(REG_LS_K, 1'b1, 32'd4);
		for (int m = 0; m < 2; m++) begin
			bus(REG_CTRL, 1'b1, (m == 1) ? 32'h0C : 32'h04);
			drive(16'h0500);
			wait_ms(65);
			check(32'({so.hs_trip, so.ls_trip}), 32'(m == 0));
			drive(16'h0000);
			wait_ms(70);
		end
		bus(REG_CTRL, 1'b1, 32'h10);
		drive(16'h0500);
		wait_ms(50);
		check(32'(so.hs_start), 32'h0);
		bus(REG_STATUS, 1'b0, 32'h0);
		check(32'(rd[8]), 32'h1);
		drive(16'h0100);
		wait_ms(210);
		drive(16'h0500);
		wait_ms(40);
		check(32'(so.hs_start), 32'h1);
		drive(16'h0000);
		wait_ms(70);
		bus(REG_CTRL, 1'b1, 32'h03);
		bus(REG_HS_THR, 1'b0, 32'h0);
		check(rd, thr_rb(1'b1, HS_THR_RST));
		bus(REG_IN_THR, 1'b0, 32'h0);
		check(rd, thr_rb(1'b1, IN_THR_RST));
		drive(16'h0900);
		wait_ms(60);
		check(32'({so.hs_start, so.in_start, so.ls_start}), 32'h1);
		bus(REG_CTRL, 1'b1, 32'h00);
		bus(REG_HS_THR, 1'b0, 32'h0);
		check(rd, thr_rb(1'b0, HS_THR_RST));
		wait_ms(40);
		// switching out mid-fault must drop outputs at once
		bus(REG_CTRL, 1'b1, 32'h03);
		@(posedge clk_i);
		check(32'({so.hs_start, so.in_start}), 32'h0);
		test_done();
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		failures++;
		test_done();
	end
endmodule
